// ==== src/fep_pkg.sv ====
// constants and types of the flash and EEPROM protect and interrupt block
package fep_pkg;
  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_ECC_STAT = 8'h08;
  localparam logic [7:0] OFS_ECC_CFG = 8'h0c;
  localparam logic [7:0] OFS_FGUARD = 8'h10;
  localparam logic [7:0] OFS_EGUARD = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  // ==========================================================
  // field positions
  localparam int ST_DONE_BIT = 0;
  localparam int ST_VIOL_BIT = 1;
  localparam int CFG_IRQ_BIT = 0;
  localparam int ECC_SGL_BIT = 0;
  localparam int ECC_DBL_BIT = 1;
  localparam int FG_OPEN_BIT = 7;
  localparam int FG_HOFF_BIT = 5;
  localparam int FG_HSZ_LSB = 3;
  localparam int FG_LOFF_BIT = 2;
  localparam int FG_LSZ_LSB = 0;
  localparam int EG_OPEN_BIT = 7;
  localparam int EG_SZ_LSB = 0;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_CODE_LSB = 16;
  // ==========================================================
  // reset values and masks
  localparam logic DONE_RST = 1'b1;
  localparam logic [7:0] FG_RST = 8'h24;
  localparam logic [7:0] EG_RST = 8'h00;
  localparam logic [7:0] FG_MASK = 8'hbf;
  localparam logic [7:0] EG_MASK = 8'h87;
  // ==========================================================
  // configuration field and protected ranges
  localparam logic [15:0] CFG_KEY_ADDR = 16'hff70;
  localparam logic [15:0] CFG_PHRASE_ADDR = 16'hff78;
  localparam logic [15:0] CFG_FG_ADDR = 16'hff7c;
  localparam logic [15:0] CFG_EG_ADDR = 16'hff7d;
  localparam logic [15:0] CFG_OPT_ADDR = 16'hff7e;
  localparam logic [15:0] CFG_SEC_ADDR = 16'hff7f;
  localparam logic [15:0] FL_LO_BASE = 16'h8000;
  localparam logic [15:0] FL_LO_UNIT = 16'h0400;
  localparam logic [15:0] FL_HI_UNIT = 16'h0800;
  localparam logic [15:0] EE_BASE = 16'h3100;
  // bit (from*8+to) set when a scenario move is allowed
  localparam logic [63:0] FG_TRANS = 64'hff5a3c18080c0a0f;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_PGM_FLASH = 8'h06;
  localparam logic [7:0] CMD_PGM_ONCE = 8'h07;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
  localparam logic [7:0] CMD_ERASE_SECT = 8'h0a;
  localparam logic [7:0] CMD_PGM_EE = 8'h11;
  localparam logic [7:0] CMD_ERASE_EE = 8'h12;
  typedef enum logic [2:0] {
    ST_LOAD_FG, ST_WAIT_FG, ST_LOAD_EG, ST_WAIT_EG, ST_IDLE, ST_BUSY
  } fep_state_type;
endpackage : fep_pkg

// ==== src/fep_top.sv ====
// flash and EEPROM protection, command launch and interrupt logic
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module fep_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fep_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic nvm_rd_req,
  output logic [15:0] nvm_addr,
  input wire logic [7:0] nvm_rd_data,
  input wire logic nvm_rd_valid,
  input wire logic nvm_ecc_single,
  input wire logic nvm_ecc_double,
  output logic nvm_cmd_start,
  output logic [7:0] nvm_cmd_code,
  input wire logic nvm_cmd_done,
  output logic cmd_irq,
  output logic err_irq
);
  import fep_pkg::*;

  // ==========================================================
  // functions
  function automatic logic fl_prot(input logic [15:0] a,
                                   input logic [7:0] g);
    logic [15:0] lo_end, hi_beg;
    logic sel;
    lo_end = FL_LO_BASE + (FL_LO_UNIT << g[FG_LSZ_LSB +: 2]) - 16'h0001;
    hi_beg = 16'h0000 - (FL_HI_UNIT << g[FG_HSZ_LSB +: 2]);
    sel = (!g[FG_LOFF_BIT] && a >= FL_LO_BASE && a <= lo_end) ||
          (!g[FG_HOFF_BIT] && a >= hi_beg);
    return g[FG_OPEN_BIT] ? sel : !sel;
  endfunction : fl_prot
  function automatic logic ee_prot(input logic [15:0] a,
                                   input logic [7:0] g);
    logic [15:0] ee_end;
    ee_end = EE_BASE + {8'h00, g[EG_SZ_LSB +: 3], 5'h1f};
    return !g[EG_OPEN_BIT] && a >= EE_BASE && a <= ee_end;
  endfunction : ee_prot
  function automatic logic trans_ok(input logic [7:0] from_g,
                                    input logic [7:0] to_g);
    logic [5:0] idx;
    idx = {from_g[FG_OPEN_BIT], from_g[FG_HOFF_BIT],
           from_g[FG_LOFF_BIT], to_g[FG_OPEN_BIT],
           to_g[FG_HOFF_BIT], to_g[FG_LOFF_BIT]};
    return FG_TRANS[idx];
  endfunction : trans_ok

  // ==========================================================
  // state
  fep_state_type state_ff;
  logic [31:0] prdata_ff;
  logic [15:0] nvm_addr_ff;
  logic [7:0] nvm_cmd_code_ff;
  logic [7:0] flash_guard_reg_ff;
  logic [7:0] eeprom_guard_reg_ff;
  logic [23:0] cmd_reg_ff;
  logic pready_ff, pslverr_ff, nvm_rd_req_ff, nvm_cmd_start_ff;
  logic cmd_irq_ff, err_irq_ff, cmd_done_flag_ff, viol_flag_ff;
  logic double_fault_flag_ff, single_fault_flag_ff, cmd_done_irq_en_ff;
  logic double_fault_irq_en_ff, single_fault_irq_en_ff;
  logic acc, wr, hit, loaded, launch, bad, launch_go, launch_bad;
  logic [31:0] rd_val;
  logic [7:0] req_code;
  logic [15:0] req_addr;
  logic [7:0] wr_fg;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign nvm_rd_req = nvm_rd_req_ff;
  assign nvm_addr = nvm_addr_ff;
  assign nvm_cmd_start = nvm_cmd_start_ff;
  assign nvm_cmd_code = nvm_cmd_code_ff;
  assign cmd_irq = cmd_irq_ff;
  assign err_irq = err_irq_ff;

  // ==========================================================
  // bus decode
  assign acc = ce && psel && penable;
  assign wr = acc && pwrite && pready_ff;
  assign loaded = (state_ff == ST_IDLE) || (state_ff == ST_BUSY);
  assign wr_fg = pwdata[7:0] & FG_MASK;

  always_comb begin
    hit = 1'b1;
    rd_val = '0;
    unique case (paddr)
      OFS_STATUS: begin
        rd_val[ST_DONE_BIT] = cmd_done_flag_ff;
        rd_val[ST_VIOL_BIT] = viol_flag_ff;
      end
      OFS_CONFIG: rd_val[CFG_IRQ_BIT] = cmd_done_irq_en_ff;
      OFS_ECC_STAT: begin
        rd_val[ECC_SGL_BIT] = single_fault_flag_ff;
        rd_val[ECC_DBL_BIT] = double_fault_flag_ff;
      end
      OFS_ECC_CFG: begin
        rd_val[ECC_SGL_BIT] = single_fault_irq_en_ff;
        rd_val[ECC_DBL_BIT] = double_fault_irq_en_ff;
      end
      OFS_FGUARD: rd_val[7:0] = flash_guard_reg_ff;
      OFS_EGUARD: rd_val[7:0] = eeprom_guard_reg_ff;
      OFS_CMD: rd_val[23:0] = cmd_reg_ff;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff <= acc && !pready_ff;
      if (acc && !pready_ff) begin
        pslverr_ff <= !hit;
        prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // ==========================================================
  // command launch check
  assign req_code = cmd_reg_ff[CMD_CODE_LSB +: 8];
  assign req_addr = cmd_reg_ff[CMD_ADDR_LSB +: 16];
  assign launch = wr && paddr == OFS_STATUS && pwdata[ST_DONE_BIT] &&
                  cmd_done_flag_ff && !viol_flag_ff &&
                  state_ff == ST_IDLE;

  always_comb begin
    bad = 1'b0;
    unique case (req_code)
      CMD_PGM_FLASH, CMD_PGM_ONCE, CMD_ERASE_SECT:
        bad = fl_prot(req_addr, flash_guard_reg_ff);
      CMD_PGM_EE, CMD_ERASE_EE:
        bad = ee_prot(req_addr, eeprom_guard_reg_ff);
      CMD_ERASE_ALL:
        bad = !(flash_guard_reg_ff[FG_OPEN_BIT] &&
                flash_guard_reg_ff[FG_HOFF_BIT] &&
                flash_guard_reg_ff[FG_LOFF_BIT] &&
                eeprom_guard_reg_ff[EG_OPEN_BIT]);
      default: bad = 1'b0;
    endcase
  end
  assign launch_go = launch && !bad;
  assign launch_bad = launch && bad;
  // ==========================================================
  // reset load and command sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_LOAD_FG;
      nvm_rd_req_ff <= 1'b0;
      nvm_addr_ff <= 16'h0000;
      nvm_cmd_start_ff <= 1'b0;
      nvm_cmd_code_ff <= 8'h00;
    end else if (ce) begin
      nvm_rd_req_ff <= 1'b0;
      nvm_cmd_start_ff <= 1'b0;
      unique case (state_ff)
        ST_LOAD_FG: begin
          nvm_rd_req_ff <= 1'b1;
          nvm_addr_ff <= CFG_FG_ADDR;
          state_ff <= ST_WAIT_FG;
        end
        ST_WAIT_FG: begin
          if (nvm_rd_valid) begin
            state_ff <= ST_LOAD_EG;
          end
        end
        ST_LOAD_EG: begin
          nvm_rd_req_ff <= 1'b1;
          nvm_addr_ff <= CFG_EG_ADDR;
          state_ff <= ST_WAIT_EG;
        end
        ST_WAIT_EG: begin
          if (nvm_rd_valid) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (launch_go) begin
            nvm_cmd_start_ff <= 1'b1;
            nvm_cmd_code_ff <= req_code;
            nvm_addr_ff <= req_addr;
            state_ff <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (nvm_cmd_done) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // protection registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_guard_reg_ff <= FG_RST;
    end else if (ce) begin
      if (state_ff == ST_WAIT_FG && nvm_rd_valid) begin
        flash_guard_reg_ff <= nvm_rd_data & FG_MASK;
      end else if (wr && paddr == OFS_FGUARD && loaded &&
                   trans_ok(flash_guard_reg_ff, wr_fg)) begin
        flash_guard_reg_ff <= wr_fg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_guard_reg_ff <= EG_RST;
    end else if (ce) begin
      if (state_ff == ST_WAIT_EG && nvm_rd_valid) begin
        eeprom_guard_reg_ff <= nvm_rd_data & EG_MASK;
      end else if (wr && paddr == OFS_EGUARD && loaded) begin
        eeprom_guard_reg_ff <= pwdata[7:0] & EG_MASK;
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_done_irq_en_ff <= 1'b0;
      double_fault_irq_en_ff <= 1'b0;
      single_fault_irq_en_ff <= 1'b0;
      cmd_reg_ff <= 24'h00_0000;
    end else if (ce && wr) begin
      if (paddr == OFS_CONFIG) begin
        cmd_done_irq_en_ff <= pwdata[CFG_IRQ_BIT];
      end
      if (paddr == OFS_ECC_CFG) begin
        double_fault_irq_en_ff <= pwdata[ECC_DBL_BIT];
        single_fault_irq_en_ff <= pwdata[ECC_SGL_BIT];
      end
      if (paddr == OFS_CMD && cmd_done_flag_ff) begin
        cmd_reg_ff <= pwdata[23:0];
      end
    end
  end

  // ==========================================================
  // status flags, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_done_flag_ff <= DONE_RST;
      viol_flag_ff <= 1'b0;
    end else if (ce) begin
      if (state_ff == ST_BUSY && nvm_cmd_done) begin
        cmd_done_flag_ff <= 1'b1;
      end else if (launch_go) begin
        cmd_done_flag_ff <= 1'b0;
      end
      viol_flag_ff <= launch_bad || (viol_flag_ff && !(wr &&
        paddr == OFS_STATUS && pwdata[ST_VIOL_BIT]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      double_fault_flag_ff <= 1'b0;
      single_fault_flag_ff <= 1'b0;
    end else if (ce) begin
      double_fault_flag_ff <= (nvm_rd_valid && nvm_ecc_double) ||
        (double_fault_flag_ff && !(wr && paddr == OFS_ECC_STAT &&
        pwdata[ECC_DBL_BIT]));
      single_fault_flag_ff <= (nvm_rd_valid && nvm_ecc_single) ||
        (single_fault_flag_ff && !(wr && paddr == OFS_ECC_STAT &&
        pwdata[ECC_SGL_BIT]));
    end
  end

  // ==========================================================
  // interrupt requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_irq_ff <= 1'b0;
      err_irq_ff <= 1'b0;
    end else if (ce) begin
      cmd_irq_ff <= cmd_done_flag_ff && cmd_done_irq_en_ff;
      err_irq_ff <= (double_fault_flag_ff && double_fault_irq_en_ff) ||
        (single_fault_flag_ff && single_fault_irq_en_ff);
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_launch;
    ce && launch;
  endsequence
  sequence s_go;
    ##1 (nvm_cmd_start_ff && !cmd_done_flag_ff && state_ff == ST_BUSY);
  endsequence
  a_cmd_irq_req: assert property (
    ce |=> cmd_irq_ff == $past(cmd_done_flag_ff && cmd_done_irq_en_ff))
    else $error("command irq does not follow flag and enable");
  a_err_irq_req: assert property (
    ce && double_fault_flag_ff && double_fault_irq_en_ff |=> err_irq_ff)
    else $error("error irq missing for enabled double fault");
  a_ecc_flag_set: assert property (
    ce && nvm_rd_valid && nvm_ecc_single |=> single_fault_flag_ff)
    else $error("single fault flag not set");
  a_fg_reset_load: assert property (
    ce && state_ff == ST_WAIT_FG && nvm_rd_valid
    |=> flash_guard_reg_ff == ($past(nvm_rd_data) & FG_MASK))
    else $error("flash guard not loaded from configuration byte");
  a_eg_reset_load: assert property (
    ce && state_ff == ST_WAIT_EG && nvm_rd_valid
    |=> eeprom_guard_reg_ff == ($past(nvm_rd_data) & EG_MASK)
        && state_ff == ST_IDLE)
    else $error("eeprom guard not loaded from configuration byte");
  a_guard_reject: assert property (
    ce && wr && paddr == OFS_FGUARD &&
    !trans_ok(flash_guard_reg_ff, wr_fg) |=> $stable(flash_guard_reg_ff))
    else $error("disallowed guard write changed protection");
  a_guard_accept: assert property (
    ce && wr && paddr == OFS_FGUARD && loaded &&
    trans_ok(flash_guard_reg_ff, wr_fg) |=> flash_guard_reg_ff == $past(wr_fg))
    else $error("allowed guard write not taken");
  a_guard_readback: assert property (
    ce && acc && !pready_ff && !pwrite && paddr == OFS_FGUARD
    |=> prdata_ff[7:0] == $past(flash_guard_reg_ff) && pready_ff)
    else $error("guard read does not show active setting");
  a_launch_go: assert property (
    s_launch ##0 !bad |-> s_go)
    else $error("clean launch did not start command");
  a_launch_bad: assert property (
    s_launch ##0 bad |=> viol_flag_ff && !nvm_cmd_start_ff)
    else $error("protected command was not blocked");
  a_done_return: assert property (
    ce && state_ff == ST_BUSY && nvm_cmd_done
    |=> cmd_done_flag_ff && state_ff == ST_IDLE)
    else $error("done flag not returned after command");
endmodule : fep_top
`default_nettype wire

// ==== test/fep_nvm_model.sv ====
// array-side partner: configuration bytes, command completion, ecc events
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// nonvolatile array model
module fep_nvm_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic nvm_rd_req,
  input wire logic [15:0] nvm_addr,
  input wire logic nvm_cmd_start,
  input wire logic [7:0] nvm_cmd_code,
  input wire logic [7:0] fg_byte,
  input wire logic [7:0] eg_byte,
  input wire logic slow,
  input wire logic [1:0] ecc_req,
  output logic [7:0] nvm_rd_data,
  output logic nvm_rd_valid,
  output logic nvm_ecc_single,
  output logic nvm_ecc_double,
  output logic nvm_cmd_done,
  output logic [7:0] last_code,
  output logic [15:0] last_addr
);
  logic rd_busy;
  logic cmd_busy;
  logic [3:0] rd_cnt;
  logic [3:0] cmd_cnt;
  logic [15:0] rd_addr;
  function automatic logic [7:0] cfg_byte(input logic [15:0] a);
    if (a == 16'hff7c) return fg_byte;
    if (a == 16'hff7d) return eg_byte;
    if (a[15:2] == 14'h3fde) return 8'hff;
    return 8'h96;
  endfunction : cfg_byte
  // ==========================================================
  // configuration reads and ecc events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_busy <= 1'b0;
      rd_cnt <= 4'h0;
      rd_addr <= 16'h0;
      nvm_rd_data <= 8'h00;
      nvm_rd_valid <= 1'b0;
      nvm_ecc_single <= 1'b0;
      nvm_ecc_double <= 1'b0;
    end else begin
      nvm_rd_valid <= 1'b0;
      nvm_ecc_single <= 1'b0;
      nvm_ecc_double <= 1'b0;
      nvm_rd_data <= ~nvm_rd_data;
      if (nvm_rd_req) begin
        rd_busy <= 1'b1;
        rd_cnt <= slow ? 4'h6 : 4'h0;
        rd_addr <= nvm_addr;
      end else if (rd_busy) begin
        if (rd_cnt == 4'h0) begin
          nvm_rd_valid <= 1'b1;
          nvm_rd_data <= cfg_byte(rd_addr);
          rd_busy <= 1'b0;
        end else begin
          rd_cnt <= rd_cnt - 4'h1;
        end
      end else if (ecc_req != 2'b00) begin
        nvm_rd_valid <= 1'b1;
        nvm_ecc_single <= ecc_req[0];
        nvm_ecc_double <= ecc_req[1];
      end
    end
  end
  // ==========================================================
  // command execution
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_busy <= 1'b0;
      cmd_cnt <= 4'h0;
      nvm_cmd_done <= 1'b0;
      last_code <= 8'h00;
      last_addr <= 16'h0;
    end else begin
      nvm_cmd_done <= 1'b0;
      if (nvm_cmd_start) begin
        cmd_busy <= 1'b1;
        cmd_cnt <= slow ? 4'hf : 4'h6;
        last_code <= nvm_cmd_code;
        last_addr <= nvm_addr;
      end else if (cmd_busy) begin
        if (cmd_cnt == 4'h0) begin
          nvm_cmd_done <= 1'b1;
          cmd_busy <= 1'b0;
        end else begin
          cmd_cnt <= cmd_cnt - 4'h1;
        end
      end
    end
  end
endmodule : fep_nvm_model
`default_nettype wire

// ==== test/tb_top.sv ====
// testbench: apb register tests of the protect and interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fep_pkg::*;
  localparam logic [7:0] OK_TBL [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08,
                                       8'h18, 8'h3c, 8'h5a, 8'hff};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err, slow, ce, nvm_rd_req, nvm_rd_valid, ecc_s, ecc_d;
  logic nvm_cmd_start, nvm_cmd_done, cmd_irq, err_irq;
  logic [15:0] nvm_addr, last_addr;
  logic [7:0] nvm_rd_data, nvm_cmd_code, last_code, fg_byte, eg_byte;
  logic [1:0] ecc_req;
  int miscompares, total_checks;
  // ==========================================================
  // design and partner
  fep_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvm_rd_req(nvm_rd_req), .nvm_addr(nvm_addr),
    .nvm_rd_data(nvm_rd_data), .nvm_rd_valid(nvm_rd_valid),
    .nvm_ecc_single(ecc_s), .nvm_ecc_double(ecc_d),
    .nvm_cmd_start(nvm_cmd_start), .nvm_cmd_code(nvm_cmd_code),
    .nvm_cmd_done(nvm_cmd_done), .cmd_irq(cmd_irq), .err_irq(err_irq));
  fep_nvm_model nvm (.pclk(pclk), .presetn(presetn),
    .nvm_rd_req(nvm_rd_req), .nvm_addr(nvm_addr),
    .nvm_cmd_start(nvm_cmd_start), .nvm_cmd_code(nvm_cmd_code),
    .fg_byte(fg_byte), .eg_byte(eg_byte), .slow(slow), .ecc_req(ecc_req),
    .nvm_rd_data(nvm_rd_data), .nvm_rd_valid(nvm_rd_valid),
    .nvm_ecc_single(ecc_s), .nvm_ecc_double(ecc_d),
    .nvm_cmd_done(nvm_cmd_done), .last_code(last_code),
    .last_addr(last_addr));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ==========================================================
  // tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task automatic do_reset(input logic [7:0] fg, input logic [7:0] eg,
                          input logic s);
    int n;
    int v;
    @(posedge pclk);
    fg_byte <= fg;
    eg_byte <= eg;
    slow <= s;
    presetn <= 1'b0;
    tick(8);
    presetn <= 1'b1;
    n = 0;
    v = 0;
    while (v < 2 && n < 100) begin
      @(posedge pclk);
      n++;
      if (nvm_rd_valid === 1'b1) v++;
    end
    if (v < 2) miscompares++;
    tick(3);
  endtask : do_reset
  function automatic logic [7:0] gbyte(input logic [2:0] s,
      input logic [1:0] h, input logic [1:0] l);
    return {s[2], 1'b0, s[1], h, s[0], l};
  endfunction : gbyte
  task automatic run_cmd(input logic [7:0] fg, input logic [7:0] eg,
      input logic [7:0] code, input logic [15:0] a, input logic v);
    int n;
    do_reset(fg, eg, a[0]);
    wr(OFS_CMD, {8'h00, code, a});
    wr(OFS_STATUS, 32'h1);
    rdchk(OFS_STATUS, v ? 32'h3 : 32'h0);
    chk({24'h0, last_code}, v ? 32'h0 : {24'h0, code});
    if (!v) chk({16'h0, last_addr}, {16'h0, a});
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 20);
    chk(rd, v ? 32'h3 : 32'h1);
  endtask : run_cmd
  // ==========================================================
  // tests
  initial begin
    int f;
    int t;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    fg_byte = 8'hff;
    eg_byte = 8'h83;
    slow = 1'b0;
    ce = 1'b1;
    ecc_req = 2'b00;
    miscompares = 0;
    total_checks = 0;
    do_reset(8'hff, 8'h83, 1'b1);
    rdchk(OFS_FGUARD, 32'hbf);
    rdchk(OFS_EGUARD, 32'h83);
    rdchk(OFS_STATUS, 32'h1);
    rdchk(OFS_CONFIG, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset_load done");
    for (f = 0; f < 8; f++) begin
      for (t = 0; t < 8; t++) begin
        do_reset(gbyte(3'(f), 2'b01, 2'b10), 8'h00, f[0]);
        wr(OFS_FGUARD, {24'h0, gbyte(3'(t), 2'b10, 2'b01) | 8'h40});
        rdchk(OFS_FGUARD, {24'h0, OK_TBL[f][t] ? gbyte(3'(t), 2'b10, 2'b01)
          : gbyte(3'(f), 2'b01, 2'b10)});
      end
    end
    $display("test transitions done");
    run_cmd(8'ha0, 8'h80, 8'h06, 16'h83ff, 1'b1);
    run_cmd(8'ha0, 8'h80, 8'h06, 16'h8400, 1'b0);
    run_cmd(8'ha3, 8'h80, 8'h0a, 16'h9fff, 1'b1);
    run_cmd(8'ha3, 8'h80, 8'h0a, 16'ha000, 1'b0);
    run_cmd(8'h84, 8'h80, 8'h06, 16'hf800, 1'b1);
    run_cmd(8'h84, 8'h80, 8'h06, 16'hf7ff, 1'b0);
    run_cmd(8'h9c, 8'h80, 8'h07, 16'hc000, 1'b1);
    run_cmd(8'h9c, 8'h80, 8'h06, 16'hbfff, 1'b0);
    run_cmd(8'h20, 8'h80, 8'h06, 16'h83ff, 1'b0);
    run_cmd(8'h20, 8'h80, 8'h06, 16'h8400, 1'b1);
    run_cmd(8'h00, 8'h80, 8'h06, 16'hf800, 1'b0);
    run_cmd(8'h24, 8'h80, 8'h0a, 16'h8400, 1'b1);
    run_cmd(8'hff, 8'h03, 8'h11, 16'h317f, 1'b1);
    run_cmd(8'hff, 8'h03, 8'h12, 16'h3180, 1'b0);
    run_cmd(8'hff, 8'h87, 8'h11, 16'h3100, 1'b0);
    run_cmd(8'hff, 8'h83, 8'h08, 16'h0000, 1'b0);
    run_cmd(8'hbf, 8'h03, 8'h08, 16'h0000, 1'b1);
    $display("test protection done");
    do_reset(8'hff, 8'h83, 1'b0);
    wr(OFS_CONFIG, 32'h1);
    tick(3);
    chk({31'h0, cmd_irq}, 32'h1);
    wr(OFS_CMD, {8'h00, CMD_PGM_FLASH, 16'h8800});
    wr(OFS_STATUS, 32'h1);
    tick(3);
    chk({31'h0, cmd_irq}, 32'h0);
    tick(12);
    chk({31'h0, cmd_irq}, 32'h1);
    wr(OFS_CONFIG, 32'h0);
    tick(3);
    chk({31'h0, cmd_irq}, 32'h0);
    for (f = 1; f < 3; f++) begin
      @(posedge pclk);
      ecc_req <= 2'(f);
      @(posedge pclk);
      ecc_req <= 2'b00;
      tick(4);
      rdchk(OFS_ECC_STAT, 32'(f));
      wr(OFS_ECC_CFG, 32'(3 - f));
      tick(3);
      chk({31'h0, err_irq}, 32'h0);
      wr(OFS_ECC_CFG, 32'(f));
      tick(3);
      chk({31'h0, err_irq}, 32'h1);
      wr(OFS_ECC_STAT, 32'(f));
      tick(3);
      chk({31'h0, err_irq}, 32'h0);
      rdchk(OFS_ECC_STAT, 32'h0);
      wr(OFS_ECC_CFG, 32'h0);
    end
    @(posedge pclk);
    ce <= 1'b0;
    ecc_req <= 2'b01;
    @(posedge pclk);
    ecc_req <= 2'b00;
    tick(4);
    ce <= 1'b1;
    rdchk(OFS_ECC_STAT, 32'h0);
    $display("test interrupts done");
    end_sim();
  end
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
